/* rtl/host_port_pkg.sv */
// Purpose: shared constants for the sixteen-bit parallel host port
// Assumes: one device clock, pins sampled through three-stage synchronisers
// Notes: location 0 is the write holding register, 1..3 are the target registers
package host_port_pkg;
    localparam int DATA_W = 16;
    localparam int IDX_W = 3;
    localparam int SEL_W = 2;
    localparam int NUM_LOC = 4;
    localparam logic [SEL_W-1:0] LOC_HOLD = 2'h0;
    localparam logic [DATA_W-1:0] WORD_RST = 16'h0000;
    // pin group order: mode, chip select, store, read/direction, index, data
    localparam int PIN_W = 4 + IDX_W + DATA_W;
    localparam int MODE_POS = PIN_W - 1;
    localparam int CS_POS = PIN_W - 2;
    localparam int STORE_POS = PIN_W - 3;
    localparam int RDDIR_POS = PIN_W - 4;
    localparam int IDX_LSB = DATA_W;
    localparam int DATA_LSB = 0;
    // strobes and chip select idle high, mode idles low as if left open
    localparam logic [PIN_W-1:0] PIN_RST = 23'h380000;
endpackage

/* rtl/pin_sync.sv */
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs asynchronous to clk_sys
// Notes: a bit changes only once stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] filt_q;
    logic [W-1:0] filt_d;

    // first stage feeds only the second one
    assign filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
    assign pin_out = filt_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            filt_q <= RST_VAL;
        end else if (ce) begin
            s1_q <= pin_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end
endmodule

/* rtl/host_parallel_port.sv */
// Purpose: sixteen-bit parallel host port with write holding register
// Assumes: host holds index, data and direction steady around each strobe edge
// Notes: pin changes take four clk_sys edges to reach the logic
// What this block does
// - host data bus is sixteen bits, bit fifteen most significant.
// - spare top index bit ignored; lower two bits select location.
// - separate-strobe mode writes on store rising edge while chip select low.
// - write latches bus into holding, or copies holding into indexed target.
// - strobe mode reuses the store pin as combined data strobe.
// - strobe mode, direction low: write on data strobe rising edge.
// - strobe mode, direction high: drive indexed location while strobe low.
// - separate-strobe mode: drive indexed location while read and chip select low.
// - direction high means read, low means write; host sets it first.
// - mode resets low, selecting separate strobes; after reset it follows the synchronised mode pin.
// - chip select is active low and qualifies every access.
`timescale 1ns/1ps
module host_parallel_port (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic ce,
    input wire logic bus_mode,
    input wire logic chip_select_n,
    input wire logic combined_data_strobe_n,
    input wire logic read_dir_n,
    input wire logic [host_port_pkg::IDX_W-1:0] index,
    input wire logic [host_port_pkg::DATA_W-1:0] data_in,
    output logic [host_port_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic [host_port_pkg::DATA_W-1:0] target_word1,
    output logic [host_port_pkg::DATA_W-1:0] target_word2,
    output logic [host_port_pkg::DATA_W-1:0] target_word3,
    output logic write_done,
    output logic commit_pulse,
    output logic [host_port_pkg::SEL_W-1:0] commit_index
);
    logic [host_port_pkg::PIN_W-1:0] pins_raw;
    logic [host_port_pkg::PIN_W-1:0] pins_s;
    logic mode_s;
    logic cs_n_s;
    logic store_n_s;
    logic rd_n_s;
    logic [host_port_pkg::IDX_W-1:0] index_s;
    logic [host_port_pkg::DATA_W-1:0] data_s;
    logic [host_port_pkg::SEL_W-1:0] loc;
    logic store_prev_q;
    logic store_rise;
    logic write_dir;
    logic write_fire;
    logic read_active;
    logic [host_port_pkg::DATA_W-1:0] rd_value;
    logic [host_port_pkg::DATA_W-1:0] loc_q [host_port_pkg::NUM_LOC];
    logic [host_port_pkg::DATA_W-1:0] data_out_q;
    logic data_oe_q;
    logic write_done_q;
    logic commit_pulse_q;
    logic [host_port_pkg::SEL_W-1:0] commit_index_q;

    assign pins_raw = {bus_mode, chip_select_n, combined_data_strobe_n, read_dir_n, index, data_in};

    // mode resets low, so separate strobes apply until the synchroniser passes the pin
    pin_sync #(
        .W(host_port_pkg::PIN_W),
        .RST_VAL(host_port_pkg::PIN_RST)
    ) u_pin_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .ce(ce),
        .pin_in(pins_raw),
        .pin_out(pins_s)
    );

    assign mode_s = pins_s[host_port_pkg::MODE_POS];
    assign cs_n_s = pins_s[host_port_pkg::CS_POS];
    assign store_n_s = pins_s[host_port_pkg::STORE_POS];
    assign rd_n_s = pins_s[host_port_pkg::RDDIR_POS];
    assign index_s = pins_s[host_port_pkg::IDX_LSB +: host_port_pkg::IDX_W];
    assign data_s = pins_s[host_port_pkg::DATA_LSB +: host_port_pkg::DATA_W];

    // spare index bit dropped here; reserved for expansion
    assign loc = index_s[host_port_pkg::SEL_W-1:0];

    // same pin is write strobe or combined strobe depending on mode
    assign store_rise = store_n_s & ~store_prev_q;
    // direction line only matters in strobe mode
    assign write_dir = mode_s ? ~rd_n_s : 1'b1;
    assign write_fire = store_rise & ~cs_n_s & write_dir;
    assign read_active = ~cs_n_s & (mode_s ? (rd_n_s & ~store_n_s) : ~rd_n_s);
    assign rd_value = loc_q[loc];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            store_prev_q <= 1'b1;
        end else if (ce) begin
            store_prev_q <= store_n_s;
        end
    end

    // holding register takes the bus; any other location takes the holding word
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < host_port_pkg::NUM_LOC; i++) begin
                loc_q[i] <= host_port_pkg::WORD_RST;
            end
        end else if (ce && write_fire) begin
            if (loc == host_port_pkg::LOC_HOLD) begin
                loc_q[loc] <= data_s;
            end else begin
                loc_q[loc] <= loc_q[host_port_pkg::LOC_HOLD];
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            write_done_q <= 1'b0;
            commit_pulse_q <= 1'b0;
            commit_index_q <= host_port_pkg::LOC_HOLD;
        end else if (ce) begin
            write_done_q <= write_fire;
            commit_pulse_q <= write_fire && (loc != host_port_pkg::LOC_HOLD);
            if (write_fire) begin
                commit_index_q <= loc;
            end
        end
    end

    // bus released outside reads so host write data never fights us
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            data_oe_q <= 1'b0;
            data_out_q <= host_port_pkg::WORD_RST;
        end else if (ce) begin
            data_oe_q <= read_active;
            if (read_active) begin
                data_out_q <= rd_value;
            end
        end
    end

    assign data_out = data_out_q;
    assign data_oe = data_oe_q;
    assign target_word1 = loc_q[1];
    assign target_word2 = loc_q[2];
    assign target_word3 = loc_q[3];
    assign write_done = write_done_q;
    assign commit_pulse = commit_pulse_q;
    assign commit_index = commit_index_q;

    property p_spare_ignored;
        @(posedge clk_sys) disable iff (rst)
        (ce && write_fire && index_s[host_port_pkg::SEL_W-1:0] == host_port_pkg::LOC_HOLD)
            |=> loc_q[host_port_pkg::LOC_HOLD] == $past(data_s);
    endproperty
    a_spare_ignored: assert property (p_spare_ignored) else $error("holding word not latched");

    property p_commit_copy;
        @(posedge clk_sys) disable iff (rst)
        (ce && write_fire && loc != host_port_pkg::LOC_HOLD)
            |=> commit_pulse_q && loc_q[commit_index_q] == $past(loc_q[host_port_pkg::LOC_HOLD]);
    endproperty
    a_commit_copy: assert property (p_commit_copy) else $error("target not loaded from holding");

    property p_sep_write;
        @(posedge clk_sys) disable iff (rst)
        (ce && !mode_s && store_n_s && !store_prev_q && !cs_n_s) |=> write_done_q;
    endproperty
    a_sep_write: assert property (p_sep_write) else $error("separate strobe write missed");

    property p_strobe_write;
        @(posedge clk_sys) disable iff (rst)
        (ce && mode_s && !rd_n_s && store_n_s && !store_prev_q && !cs_n_s) |=> write_done_q;
    endproperty
    a_strobe_write: assert property (p_strobe_write) else $error("strobe mode write missed");

    property p_dir_read_blocks_write;
        @(posedge clk_sys) disable iff (rst)
        (ce && mode_s && rd_n_s) |=> !write_done_q;
    endproperty
    a_dir_read_blocks_write: assert property (p_dir_read_blocks_write) else $error("write during read");

    property p_strobe_read;
        @(posedge clk_sys) disable iff (rst)
        (ce && mode_s && rd_n_s && !store_n_s && !cs_n_s) |=> data_oe_q && data_out_q == $past(rd_value);
    endproperty
    a_strobe_read: assert property (p_strobe_read) else $error("strobe mode read not driven");

    property p_sep_read;
        @(posedge clk_sys) disable iff (rst)
        (ce && !mode_s && !rd_n_s && !cs_n_s) |=> data_oe_q && data_out_q == $past(rd_value);
    endproperty
    a_sep_read: assert property (p_sep_read) else $error("separate read not driven");

    property p_strobe_pin_reused;
        @(posedge clk_sys) disable iff (rst)
        (ce && mode_s && store_n_s) |=> !data_oe_q;
    endproperty
    a_strobe_pin_reused: assert property (p_strobe_pin_reused) else $error("read without data strobe");

    property p_cs_gates;
        @(posedge clk_sys) disable iff (rst)
        (ce && cs_n_s) |=> !data_oe_q && !write_done_q;
    endproperty
    a_cs_gates: assert property (p_cs_gates) else $error("access without chip select");

    property p_oe_only_read;
        @(posedge clk_sys) disable iff (rst)
        (ce && !read_active) |=> !data_oe_q;
    endproperty
    a_oe_only_read: assert property (p_oe_only_read) else $error("bus driven outside read");
endmodule

/* bench/host_model.sv */
// Purpose: host processor driving the parallel port pins
// Assumes: host-driven pins change at falling clock edges only
// Notes: unowned bus shows a toggling pattern, never the last value
`timescale 1ns/1ps
module host_model (
    input wire logic clk_sys,
    input wire logic [host_port_pkg::DATA_W-1:0] data_out,
    input wire logic data_oe,
    output logic bus_mode,
    output logic chip_select_n,
    output logic combined_data_strobe_n,
    output logic read_dir_n,
    output logic [host_port_pkg::IDX_W-1:0] index,
    output logic [host_port_pkg::DATA_W-1:0] data_in
);
    logic drv = 1'b0;
    logic tog = 1'b0;
    logic got = 1'b0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata = 16'h0000;
    always @(posedge clk_sys) tog <= ~tog;
    assign data_in = drv ? wdata : (data_oe === 1'b1 ? data_out : {8{tog, ~tog}});
    initial begin
        bus_mode = 1'b0;
        chip_select_n = 1'b1;
        combined_data_strobe_n = 1'b1;
        read_dir_n = 1'b1;
        index = 3'h0;
    end
    task automatic access(input logic m, input logic cs_n, input logic rd, input logic [2:0] idx,
                          input logic [15:0] d);
        int i;
        @(negedge clk_sys);
        bus_mode = m;
        index = idx;
        read_dir_n = m ? rd : 1'b1;
        drv = !rd;
        wdata = d;
        got = 1'b0;
        // chip select after mode settles, so no stray read is seen
        repeat (2) @(negedge clk_sys);
        chip_select_n = cs_n;
        repeat (5) @(negedge clk_sys);
        if (rd && !m) read_dir_n = 1'b0;
        else combined_data_strobe_n = 1'b0;
        if (rd) begin
            for (i = 0; i < 12 && !got; i++) begin
                @(negedge clk_sys);
                got = (data_oe === 1'b1);
            end
            repeat (2) @(negedge clk_sys);
            rdata = data_out;
        end else repeat (3) @(negedge clk_sys);
        combined_data_strobe_n = 1'b1;
        if (!m) read_dir_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        drv = 1'b0;
        chip_select_n = 1'b1;
    endtask
endmodule

/* bench/tb_host_parallel_port.sv */
// Purpose: random and corner-case test of the parallel host port
// Assumes: clock enable high except in one freeze scenario
// Notes: expected words come from a shadow of holding and targets
`timescale 1ns/1ps
module tb_host_parallel_port;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    int w_frz;
    logic bus_mode, chip_select_n, combined_data_strobe_n, read_dir_n, data_oe, write_done, commit_pulse;
    logic [host_port_pkg::IDX_W-1:0] index;
    logic [15:0] data_in, data_out, target_word1, target_word2, target_word3, hold_m;
    logic [15:0] tgt_m [4];
    logic [host_port_pkg::SEL_W-1:0] commit_index;
    int n_mismatch = 0;
    int n_checks = 0;
    int n_wr = 0;
    int n_cm = 0;
    int k;
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        if (write_done === 1'b1) n_wr <= n_wr + 1;
        if (commit_pulse === 1'b1) n_cm <= n_cm + 1;
    end
    host_parallel_port dut_u (.clk_sys(clk_sys), .rst(rst), .ce(ce), .bus_mode(bus_mode),
        .chip_select_n(chip_select_n), .combined_data_strobe_n(combined_data_strobe_n),
        .read_dir_n(read_dir_n), .index(index), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe), .target_word1(target_word1), .target_word2(target_word2),
        .target_word3(target_word3), .write_done(write_done), .commit_pulse(commit_pulse),
        .commit_index(commit_index));
    host_model host_u (.clk_sys(clk_sys), .data_out(data_out), .data_oe(data_oe), .bus_mode(bus_mode),
        .chip_select_n(chip_select_n), .combined_data_strobe_n(combined_data_strobe_n),
        .read_dir_n(read_dir_n), .index(index), .data_in(data_in));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    function automatic logic [15:0] exp_word(input logic [2:0] idx);
        return idx[1:0] == 2'h0 ? hold_m : tgt_m[idx[1:0]];
    endfunction
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic op(input logic m, input logic cs_n, input logic rd, input logic [2:0] idx, input logic [15:0] d);
        int w0;
        int c0;
        w0 = n_wr;
        c0 = n_cm;
        host_u.access(m, cs_n, rd, idx, d);
        if (rd) begin
            check(16'(host_u.got), 16'(!cs_n), "read drive");
            if (!cs_n && host_u.got !== 1'b1) end_of_test();
            if (!cs_n) check(host_u.rdata, exp_word(idx), "read data");
        end else if (!cs_n) begin
            if (idx[1:0] == 2'h0) hold_m = d;
            else tgt_m[idx[1:0]] = hold_m;
            check(16'(commit_index), 16'(idx[1:0]), "commit index");
        end
        check(16'(data_oe), 16'h0000, "bus released");
        check(16'(n_wr - w0), 16'(!cs_n && !rd), "write count");
        check(16'(n_cm - c0), 16'(!cs_n && !rd && idx[1:0] != 2'h0), "commit count");
        check(target_word1, tgt_m[1], "target one");
        check(target_word2, tgt_m[2], "target two");
        check(target_word3, tgt_m[3], "target three");
    endtask
    initial begin
        hold_m = 16'h0000;
        tgt_m = '{default: 16'h0000};
        repeat (20) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        check(target_word1 | target_word2 | target_word3, 16'h0000, "reset targets");
        check(16'(data_oe), 16'h0000, "reset bus");
        void'($urandom(69));
        // spare bit set, msb and lsb both live, then refused accesses
        op(1'b0, 1'b0, 1'b0, 3'h4, 16'h8001);
        op(1'b0, 1'b0, 1'b0, 3'h3, 16'h1234);
        op(1'b1, 1'b0, 1'b1, 3'h7, 16'h0000);
        op(1'b0, 1'b1, 1'b0, 3'h1, 16'hffff);
        op(1'b1, 1'b1, 1'b1, 3'h2, 16'h0000);
        // a whole write while frozen must leave no trace once enable returns
        @(negedge clk_sys) ce = 1'b0;
        w_frz = n_wr;
        host_u.access(1'b0, 1'b0, 1'b0, 3'h1, 16'h5a5a);
        @(negedge clk_sys) ce = 1'b1;
        repeat (8) @(negedge clk_sys);
        check(16'(n_wr - w_frz), 16'h0000, "frozen write");
        check(target_word1, tgt_m[1], "frozen target");
        for (k = 0; k < 40; k++) begin
            op(1'($urandom), 1'($urandom % 8 == 0), 1'($urandom), 3'($urandom), 16'($urandom));
        end
        end_of_test();
    end
endmodule
